/* hw/wire_master_pkg.sv */
// Constants and carrier types for the single-wire bus master
package wire_master_pkg;

    // ----------------------------------------
    // Clock and tick
    // ----------------------------------------
    localparam int CLK_MHZ          = 20;
    localparam int TICK_DIV_DEFAULT = CLK_MHZ;
    localparam int DIV_WIDTH        = 8;

    // ----------------------------------------
    // Durations in microseconds and their counter width
    // ----------------------------------------
    localparam int RESET_LOW_TIME_US      = 511;
    localparam int RESET_RECOVERY_TIME_US = 512;
    localparam int PRESENCE_SAMPLE_US     = 70;
    localparam int ZERO_LOW_TIME_US       = 100;
    localparam int SLOT_DURATION_US       = 117;
    localparam int SHORT_LOW_TIME_US      = 5;
    localparam int READ_SAMPLE_US         = 13;
    localparam int US_WIDTH               = 10;

    // ----------------------------------------
    // Commands and carriers
    // ----------------------------------------
    typedef enum logic [1:0]
    {
        CMD_RESET = 2'h0,
        CMD_WRITE = 2'h1,
        CMD_READ  = 2'h2
    } cmd_type;

    typedef struct packed
    {
        cmd_type cmd;
        logic    bitValue;
    } request_type;

    typedef struct packed
    {
        logic presence;
        logic bitValue;
    } result_type;

endpackage

/* hw/us_tick_divider.sv */
// Programmable divider producing a one-microsecond enable pulse
`timescale 1ns/1ps
module us_tick_divider
#(
    parameter int WIDTH = 8
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Divide ratio, cycles per tick
    input  wire logic [WIDTH-1:0] divisor,
    // Tick pulse
    output logic                  tick
);
    logic [WIDTH-1:0] count_q;

    initial
    begin
        if (WIDTH < 2)
            $error("us_tick_divider: WIDTH must be at least 2");
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count_q <= '0;
            tick    <= 1'b0;
        end
        else if (count_q + WIDTH'(1) >= divisor)
        begin
            count_q <= '0;
            tick    <= 1'b1;
        end
        else
        begin
            count_q <= count_q + WIDTH'(1);
            tick    <= 1'b0;
        end
    end
endmodule

/* hw/wire_master.sv */
// Single-wire bus master: reset/presence, write and read slots
//
// Behaviour
// R1: Reset pulse holds line low at least 480 us, nominally 511 us.
// R2: Slave waits 15 to 60 us of high line before presence.
// R3: Slave presence low lasts 60 to 240 us; low seen means detected.
// R4: Line stays released at least 480 us, nominally 512, after reset.
// R5: Zero bit drives line low 60 to 120 us, nominally 100.
// R6: Zero slot lasts up to 120 us, nominally 117, before next slot.
// R7: One bit or read starts with 1 to 15 us low, nominally 5.
// R8: One or read slot lasts 60 to 120 us, nominally 117.
// R9: Slave driving zero releases 15 to 45 us after slot start.
// R10: Read samples line once, after own low, before slave release.
// R11: All durations counted on a 1 us tick from programmable divider.
`timescale 1ns/1ps
module wire_master
#(
    parameter int RESET_LOW_US      = wire_master_pkg::RESET_LOW_TIME_US,
    parameter int RESET_RECOVERY_US = wire_master_pkg::RESET_RECOVERY_TIME_US
)
(
    // Clock and reset
    input  wire logic                                  clk,
    input  wire logic                                  rst,
    // Tick divider ratio, clock cycles per microsecond
    input  wire logic [wire_master_pkg::DIV_WIDTH-1:0] tickDivisor,
    // Request
    input  wire logic                                  reqValid,
    input  wire_master_pkg::request_type               reqData,
    output logic                                       reqReady,
    // Result
    output logic                                       doneValid,
    output wire_master_pkg::result_type                doneData,
    // Open-drain line
    input  wire logic                                  lineIn,
    output logic                                       lineOut,
    output logic                                       lineOe
);
    import wire_master_pkg::*;

    initial
    begin
        if (RESET_LOW_US < 480 || RESET_RECOVERY_US < 480)
            $error("wire_master: reset times below 480 us");
        if (RESET_LOW_US >= (1 << US_WIDTH) || RESET_RECOVERY_US >= (1 << US_WIDTH))
            $error("wire_master: reset times exceed counter");
    end

    // ----------------------------------------
    // Tick and line synchroniser
    // ----------------------------------------
    logic tick;
    logic lineMeta_q;
    logic lineSync_q;

    // R11: microsecond tick
    us_tick_divider #(.WIDTH(DIV_WIDTH)) tickGen
    (
        .clk     (clk),
        .rst     (rst),
        .divisor (tickDivisor),
        .tick    (tick)
    );

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lineMeta_q <= 1'b1;
            lineSync_q <= 1'b1;
        end
        else
        begin
            lineMeta_q <= lineIn;
            lineSync_q <= lineMeta_q;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    typedef enum logic [2:0]
    {
        ST_IDLE     = 3'h0,
        ST_RST_LOW  = 3'h1,
        ST_RST_HIGH = 3'h2,
        ST_SLOT     = 3'h3,
        ST_DONE     = 3'h4
    } state_type;

    state_type         state_q;
    request_type       req_q;
    logic [US_WIDTH-1:0] us_q;
    logic              sample_q;
    logic              presence_q;

    // Low time of the current slot in microseconds
    function automatic logic [US_WIDTH-1:0] slotLow(input request_type r);
        if (r.cmd == CMD_WRITE && !r.bitValue)
            slotLow = US_WIDTH'(ZERO_LOW_TIME_US);
        else
            slotLow = US_WIDTH'(SHORT_LOW_TIME_US);
    endfunction

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            req_q   <= '{cmd: CMD_RESET, bitValue: 1'b0};
            us_q    <= '0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    us_q <= '0;
                    if (reqValid)
                    begin
                        req_q   <= reqData;
                        state_q <= (reqData.cmd == CMD_RESET) ? ST_RST_LOW : ST_SLOT;
                    end
                end
                // R1: reset low time
                ST_RST_LOW:
                    if (tick)
                    begin
                        if (us_q == US_WIDTH'(RESET_LOW_US - 1))
                        begin
                            us_q    <= '0;
                            state_q <= ST_RST_HIGH;
                        end
                        else
                            us_q <= us_q + US_WIDTH'(1);
                    end
                // R4: recovery before next slot
                ST_RST_HIGH:
                    if (tick)
                    begin
                        if (us_q == US_WIDTH'(RESET_RECOVERY_US - 1))
                            state_q <= ST_DONE;
                        else
                            us_q <= us_q + US_WIDTH'(1);
                    end
                // R6: slot duration, zero and one alike
                // R8: one or read slot length
                ST_SLOT:
                    if (tick)
                    begin
                        if (us_q == US_WIDTH'(SLOT_DURATION_US - 1))
                            state_q <= ST_DONE;
                        else
                            us_q <= us_q + US_WIDTH'(1);
                    end
                ST_DONE:
                    state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Line drive
    // ----------------------------------------
    // Pin only ever pulls low; high comes from the pull-up
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lineOe  <= 1'b0;
            lineOut <= 1'b0;
        end
        else
        begin
            lineOut <= 1'b0;
            if (state_q == ST_IDLE && reqValid)
                lineOe <= 1'b1;
            else if (state_q == ST_RST_LOW)
                lineOe <= !(tick && us_q == US_WIDTH'(RESET_LOW_US - 1));
            // R5: zero held low; R7: short low then release
            else if (state_q == ST_SLOT)
                lineOe <= lineOe && !(tick && us_q == slotLow(req_q) - US_WIDTH'(1));
            else
                lineOe <= 1'b0;
        end
    end

    // ----------------------------------------
    // Sampling
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sample_q   <= 1'b1;
            presence_q <= 1'b0;
        end
        else
        begin
            if (state_q == ST_IDLE && reqValid)
            begin
                sample_q   <= 1'b1;
                presence_q <= 1'b0;
            end
            // R3: low inside presence window means slave found
            if (state_q == ST_RST_HIGH && tick && us_q == US_WIDTH'(PRESENCE_SAMPLE_US))
                presence_q <= !lineSync_q;
            // R10: single sample before slave release (R9)
            if (state_q == ST_SLOT && tick && us_q == US_WIDTH'(READ_SAMPLE_US))
                sample_q <= lineSync_q;
        end
    end

    // ----------------------------------------
    // Handshake outputs
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            reqReady  <= 1'b1;
            doneValid <= 1'b0;
            doneData  <= '0;
        end
        else
        begin
            reqReady  <= (state_q == ST_DONE) || (state_q == ST_IDLE && !reqValid);
            doneValid <= (state_q == ST_DONE);
            if (state_q == ST_DONE)
            begin
                doneData.presence <= presence_q;
                doneData.bitValue <= (req_q.cmd == CMD_READ) ? sample_q : req_q.bitValue;
            end
        end
    end
endmodule

/* tb/wire_master_props.sv */
// Assertion checker for the single-wire bus master
`timescale 1ns/1ps
module wire_master_props
#(
    parameter int RESET_LOW_US      = 511,
    parameter int RESET_RECOVERY_US = 512
)
(
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   rst,
    // Control side
    input wire logic [7:0]             tickDivisor,
    input wire logic                   reqValid,
    input wire_master_pkg::request_type reqData,
    input wire logic                   reqReady,
    input wire logic                   doneValid,
    // Line drive
    input wire logic                   lineOe
);
    import wire_master_pkg::*;
    cmd_type kind_q;
    logic    bit_q;
    int      div;
    int      lowCnt_q;
    int      relCnt_q;
    int      busyCnt_q;
    assign div = int'(tickDivisor);
    always_ff @(posedge clk)
    begin
        if (rst)
            kind_q <= CMD_RESET;
        else if (reqValid && reqReady && !lineOe)
        begin
            kind_q <= reqData.cmd;
            bit_q  <= reqData.bitValue;
        end
    end
    // Cycle counts; tick phase may cost one tick
    always_ff @(posedge clk)
    begin
        lowCnt_q  <= lineOe ? lowCnt_q + 1 : 0;
        relCnt_q  <= lineOe ? 0 : relCnt_q + 1;
        busyCnt_q <= (reqValid && reqReady) ? 0 : busyCnt_q + 1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    reset_low_a: assert property (
        $fell(lineOe) && kind_q == CMD_RESET |->
        lowCnt_q >= 480 * div && lowCnt_q <= (RESET_LOW_US + 1) * div)
        else $error("reset pulse length out of range");
    recovery_a: assert property (
        doneValid && kind_q == CMD_RESET |->
        relCnt_q >= 480 * div && relCnt_q <= (RESET_RECOVERY_US + 2) * div)
        else $error("reset recovery length out of range");
    zero_low_a: assert property (
        $fell(lineOe) && kind_q == CMD_WRITE && !bit_q |->
        lowCnt_q >= 60 * div && lowCnt_q <= 120 * div)
        else $error("zero bit low time out of range");
    short_low_a: assert property (
        $fell(lineOe) && (kind_q == CMD_READ || (kind_q == CMD_WRITE && bit_q)) |->
        lowCnt_q >= div && lowCnt_q <= 15 * div)
        else $error("short low time out of range");
    slot_len_a: assert property (
        doneValid && kind_q != CMD_RESET |->
        busyCnt_q >= 60 * div && busyCnt_q <= 120 * div)
        else $error("slot duration out of range");
    drive_start_a: assert property (
        reqValid && reqReady |-> ##[1:2] lineOe)
        else $error("line not pulled at slot start");
    single_low_a: assert property (
        $rose(lineOe) |-> busyCnt_q <= 2)
        else $error("second low pulse inside one slot");
    done_pulse_a: assert property (
        doneValid |=> !doneValid)
        else $error("done held longer than one cycle");
endmodule
bind wire_master wire_master_props
#(
    .RESET_LOW_US      (RESET_LOW_US),
    .RESET_RECOVERY_US (RESET_RECOVERY_US)
)
props_u
(
    .clk         (clk),
    .rst         (rst),
    .tickDivisor (tickDivisor),
    .reqValid    (reqValid),
    .reqData     (reqData),
    .reqReady    (reqReady),
    .doneValid   (doneValid),
    .lineOe      (lineOe)
);

/* tb/wire_slave_model.sv */
// Behavioural slave device on the pulled-up single-wire line
`timescale 1ns/1ps
module wire_slave_model
#(
    parameter int US_NS = 1000
)
(
    // Line and behaviour controls
    input wire logic line,
    input wire logic present,
    input wire logic readZero,
    input wire logic slow,
    // Open-drain pull
    output logic     pullLow,
    // Bit seen 30 us into the last master low: write, read or reset
    output logic     seenBit
);
    realtime fellAt = 0.0;
    initial pullLow = 1'b0;
    initial seenBit = 1'b1;
    always @(negedge line)
    begin
        if (!pullLow)
        begin
            #(30 * US_NS);
            seenBit = line;
        end
    end
    // zero held, released 16 or 40 us
    always @(negedge line)
    begin
        if (!pullLow)
        begin
            fellAt = $realtime;
            if (readZero)
            begin
                pullLow = 1'b1;
                #((slow ? 40 : 16) * US_NS);
                pullLow = 1'b0;
            end
        end
    end
    always @(posedge line)
    begin
        if (present && $realtime - fellAt >= 480 * US_NS)
        begin
            #((slow ? 59 : 15) * US_NS);
            pullLow = 1'b1;
            #((slow ? 240 : 60) * US_NS);
            pullLow = 1'b0;
            // Own release must not look like a reset
            fellAt = $realtime;
        end
    end
endmodule

/* tb/test_wire_master.sv */
// Self-checking bench for the single-wire bus master
`timescale 1ns/1ps
module test_wire_master;
    import wire_master_pkg::*;
    logic        clk;
    logic        rst;
    logic        reqValid;
    request_type reqData;
    logic        reqReady;
    logic        doneValid;
    result_type  doneData;
    logic        lineOe;
    logic        lineOut;
    logic        seenBit;
    logic        pullLow;
    logic        present;
    logic        readZero;
    logic        slow;
    cmd_type     c;
    logic        b;
    int          n_fail;
    int          n_tests;
    wire         line = (lineOe ? lineOut : 1'b1) && !pullLow;
    wire_master dut_u
    (
        .clk         (clk),
        .rst         (rst),
        .tickDivisor (8'(TICK_DIV_DEFAULT)),
        .reqValid    (reqValid),
        .reqData     (reqData),
        .reqReady    (reqReady),
        .doneValid   (doneValid),
        .doneData    (doneData),
        .lineIn      (line),
        .lineOut     (lineOut),
        .lineOe      (lineOe)
    );
    wire_slave_model slave_u
    (
        .line     (line),
        .present  (present),
        .readZero (readZero),
        .slow     (slow),
        .pullLow  (pullLow),
        .seenBit  (seenBit)
    );
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %b seen %b", name, exp, got);
            n_fail++;
        end
    endtask
    task automatic run_op(input cmd_type op, input logic v);
        int n;
        @(posedge clk);
        #1;
        reqValid = 1'b1;
        reqData  = '{op, v};
        n = 0;
        while (reqReady !== 1'b0 && n < 8)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check("request taken", 1'b0, reqReady);
        reqValid = 1'b0;
        n = 0;
        while (doneValid !== 1'b1 && n < 25000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check("done", 1'b1, doneValid);
        check("line out", 1'b0, lineOut);
    endtask
    task automatic end_sim();
        if (n_fail == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        rst = 1'b1;
        reqValid = 1'b0;
        reqData = '0;
        {present, readZero, slow} = 3'h4;
        n_fail = 0;
        n_tests = 0;
        void'($urandom(61));
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        // Prompt, slow and absent slave
        for (int k = 0; k < 3; k++)
        begin
            present = (k != 2);
            slow    = (k == 1);
            run_op(CMD_RESET, 1'b0);
            check("presence", present, doneData.presence);
        end
        present = 1'b1;
        // First four fixed: write 0, write 1, read 0, read 1
        for (int k = 0; k < 10; k++)
        begin
            c = (k < 4) ? ((k < 2) ? CMD_WRITE : CMD_READ) : cmd_type'($urandom_range(1, 2));
            b = (k < 4) ? k[0] : 1'($urandom);
            slow = 1'($urandom);
            readZero = (c == CMD_READ) && !b;
            run_op(c, b);
            check("bit", b, doneData.bitValue);
            if (c == CMD_WRITE)
                check("written bit", b, seenBit);
        end
        // Reset in mid-slot, then a clean slot
        readZero = 1'b0;
        @(posedge clk);
        #1;
        reqValid = 1'b1;
        reqData  = '{CMD_WRITE, 1'b0};
        @(posedge clk);
        #1;
        reqValid = 1'b0;
        repeat (40) @(posedge clk);
        #1;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        check("oe after reset", 1'b0, lineOe);
        check("ready after reset", 1'b1, reqReady);
        check("done after reset", 1'b0, doneValid);
        check("data after reset", 1'b0, |doneData);
        // Let the slave's mid-slot sample of the cut slot lapse
        repeat (700) @(posedge clk);
        run_op(CMD_WRITE, 1'b1);
        check("written bit", 1'b1, seenBit);
        end_sim();
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        n_fail++;
        end_sim();
    end
endmodule
